// ### rtl/serial_in_latched_parallel_out.sv
`timescale 1ns/1ps

// Summary of operation
// - Shift clock rise shifts up, loads stage zero
// - Cascade output takes previous stage six value
// - Latch clock rise copies stages into latch
// - Simultaneous clocks latch pre-shift contents
// - Clear low zeroes stages and cascade output
// - Clear leaves storage latch untouched
// - Latch clock during clear loads zeros
// - Enable low drives latch onto outputs
// - Enable high floats outputs; cascade stays driven
module serial_in_latched_parallel_out
#(
    parameter int WIDTH = shift_latch_pkg::STAGE_COUNT
)
(
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             shift_clock_in,
    input  wire logic             latch_clock_in,
    input  wire logic             serial_in,
    input  wire logic             clear_n,
    input  wire logic             output_enable_n,
    output logic [WIDTH-1:0]      parallel_out,
    output logic [WIDTH-1:0]      parallel_out_en,
    output logic                  cascade_out
);
    import shift_latch_pkg::*;

    // ------------------------------------------------------------------
    // Edge detection of the pin clocks
    // ------------------------------------------------------------------
    // Pin clocks are sampled on the system clock, so edges are found by
    // comparing with the previous sample; pulses that span no rising system clock edge are lost.
    logic             shift_clock_prev;
    logic             latch_clock_prev;
    logic             shift_rise;
    logic             latch_rise;
    logic [WIDTH-1:0] shift_stage_bits;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            shift_clock_prev <= BIT_LOW;
            latch_clock_prev <= BIT_LOW;
        end
        else
        begin
            shift_clock_prev <= shift_clock_in;
            latch_clock_prev <= latch_clock_in;
        end
    end

    assign shift_rise = shift_clock_in & ~shift_clock_prev;
    assign latch_rise = latch_clock_in & ~latch_clock_prev;

    // ------------------------------------------------------------------
    // Shift stages
    // ------------------------------------------------------------------
    // Clear acts at once on the stages, independent of the pin clocks;
    // here it is a level seen each system clock, so it dominates shifting.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            shift_stage_bits <= WIDTH'(STAGES_CLEAR);
        end
        else if (!clear_n)
        begin
            shift_stage_bits <= WIDTH'(STAGES_CLEAR);
        end
        else if (shift_rise)
        begin
            shift_stage_bits <= {shift_stage_bits[WIDTH-2:0], serial_in};
        end
    end

    // ------------------------------------------------------------------
    // Cascade output
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cascade_out <= BIT_LOW;
        end
        else if (!clear_n)
        begin
            cascade_out <= BIT_LOW;
        end
        else if (shift_rise)
        begin
            cascade_out <= shift_stage_bits[WIDTH-2];
        end
    end

    // ------------------------------------------------------------------
    // Storage latch and output drivers
    // ------------------------------------------------------------------
    // The latch reads the stages before this cycle's shift lands, so tied
    // clocks leave it one pulse behind. Clear itself never touches it.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            parallel_out <= WIDTH'(LATCH_RESET);
        end
        else if (latch_rise)
        begin
            if (!clear_n)
            begin
                parallel_out <= WIDTH'(STAGES_CLEAR);
            end
            else
            begin
                parallel_out <= shift_stage_bits;
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            parallel_out_en <= '0;
        end
        else
        begin
            parallel_out_en <= {WIDTH{~output_enable_n}};
        end
    end

endmodule

// ### rtl/shift_latch_pkg.sv
package shift_latch_pkg;

    // ------------------------------------------------------------------
    // Geometry and reset values
    // ------------------------------------------------------------------
    localparam int            STAGE_COUNT  = 8;
    localparam int            TAP_STAGE    = 6;
    localparam logic [7:0]    STAGES_CLEAR = 8'h00;
    localparam logic [7:0]    LATCH_RESET  = 8'h00;
    localparam logic          BIT_LOW      = 1'b0;

endpackage

// ### tb/host_model.sv
`timescale 1ns/1ps
module host_model (input wire logic clock, go, tied, input wire logic [7:0] data,
    output logic ser = 1'b0, sck = 1'b0, lck = 1'b0, done = 1'b0);
    // Pin clocks idle low; data line flips once released
    always @(posedge go)
    begin
        done <= 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            @(negedge clock) {ser, sck, lck} <= {data[i], 2'b00};
            @(negedge clock) {sck, lck} <= {1'b1, tied};
        end
        @(negedge clock) {ser, sck, lck} <= {~ser, 2'b00};
        @(negedge clock) lck <= ~tied;
        @(negedge clock) {lck, done} <= 2'b01;
    end
endmodule

// ### tb/slpo_props.sv
`timescale 1ns/1ps
module slpo_props #(parameter int WIDTH = 8) (input wire logic clock, rst, shift_clock_in,
    latch_clock_in, serial_in, clear_n, output_enable_n, cascade_out,
    input wire logic [WIDTH-1:0] parallel_out, parallel_out_en);
    logic [WIDTH-1:0] mirror;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence latch_rise; $rose(latch_clock_in); endsequence
    always_ff @(posedge clock or posedge rst)
        if (rst) mirror <= '0;
        else if (!clear_n) mirror <= '0;
        else if ($rose(shift_clock_in)) mirror <= {mirror[WIDTH-2:0], serial_in};
    cascade_tap_a: assert property (cascade_out == mirror[WIDTH-1])
        else $error("bad cascade");
    latch_copy_a: assert property (clear_n ##0 latch_rise |=> parallel_out == $past(mirror))
        else $error("bad latch");
    clear_zero_a: assert property (!clear_n |=> !cascade_out) else $error("no clear");
    out_hold_a: assert property (!$rose(latch_clock_in) |=> $stable(parallel_out))
        else $error("latch moved");
    clear_load_a: assert property (!clear_n ##0 latch_rise |=> parallel_out == '0)
        else $error("no zero load");
    drive_en_a: assert property (1 |=> parallel_out_en == {WIDTH{!$past(output_enable_n)}})
        else $error("bad enable");
    en_equal_a: assert property (parallel_out_en == '0 || parallel_out_en == '1)
        else $error("split enable");
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clock = 0, rst = 1, clear_n = 1, oe_n = 0, go = 0, tied = 0, ser, sck, lck, casc, done;
    logic [7:0] data = 8'h00, pout, pen;
    int fail_count = 0, n_checks = 0;
    initial forever #10 clock = ~clock;
    host_model host (.clock(clock), .go(go), .tied(tied), .data(data), .ser(ser), .sck(sck),
        .lck(lck), .done(done));
    serial_in_latched_parallel_out dut (.clock(clock), .rst(rst), .shift_clock_in(sck),
        .latch_clock_in(lck), .serial_in(ser), .clear_n(clear_n), .output_enable_n(oe_n),
        .parallel_out(pout), .parallel_out_en(pen), .cascade_out(casc));
    task chk(input logic [7:0] s, e);
        n_checks++;
        if (s !== e)
        begin
            fail_count++;
            $display("[ERR] %0t %h %h", $time, s, e);
        end
    endtask
    task finish_test;
        if (fail_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task send(input logic [7:0] d, input logic t);
        @(negedge clock) {data, tied, go} = {d, t, 1'b1};
        @(negedge clock) go = 0;
        for (int i = 0; i < 60 && !done; i++) @(negedge clock);
        if (!done)
        begin
            fail_count++;
            finish_test;
        end
    endtask
    task t_shift;
        send(8'hA5, 0);
        chk(pout, 8'hA5);
        chk(casc, 8'h01);
        chk(pen, 8'hFF);
    endtask
    task t_tied;
        send(8'h3C, 1);
        chk(pout, 8'h9E);
        chk(casc, 8'h00);
    endtask
    task t_clear;
        @(negedge clock) clear_n = 0;
        repeat (2) @(negedge clock);
        chk(casc, 8'h00);
        chk(pout, 8'h9E);
        send(8'hFF, 0); chk(pout, 8'h00); clear_n = 1;
    endtask
    task t_float;
        oe_n = 1;
        send(8'hC3, 0);
        chk(pen, 8'h00);
        chk(casc, 8'h01);
        oe_n = 0;
        repeat (2) @(negedge clock);
        chk(pen, 8'hFF);
        chk(pout, 8'hC3);
    endtask
    task t_reset;
        // Mid-run reset: outputs drop at once, then a fresh frame lands
        rst = 1;
        @(negedge clock);
        chk(pout, 8'h00);
        chk(pen, 8'h00);
        chk(casc, 8'h00);
        rst = 0;
        repeat (2) @(negedge clock);
        chk(pen, 8'hFF);
        send(8'h5A, 0);
        chk(pout, 8'h5A);
        chk(casc, 8'h00);
    endtask
    initial
    begin
        repeat (6) @(negedge clock);
        rst = 0;
        t_shift;
        t_tied;
        t_clear;
        t_float;
        t_reset;
        finish_test;
    end
endmodule
bind serial_in_latched_parallel_out slpo_props #(.WIDTH(WIDTH)) props (.*);
